/* pkg/spc_cfg.svh */
// Constants for the segment protection checker.
// Assumes nothing; included by bare name.
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH
`define SPC_NSEG 6
`define SPC_SEG_CS 3'h1
`define SPC_SEG_SS 3'h2
`define SPC_SEG_TEST 3'h7
`define SPC_AB_P 7
`define SPC_AB_DPL_HI 6
`define SPC_AB_DPL_LO 5
`define SPC_AB_S 4
`define SPC_AB_E 3
`define SPC_AB_ED 2
`define SPC_AB_W 1
`define SPC_AB_A 0
`define SPC_D_LIM_HI 15
`define SPC_D_BASE_LO 16
`define SPC_D_BASE_HI 39
`define SPC_D_ACC_LO 40
`define SPC_D_ACC_HI 47
`define SPC_D_LIMX_LO 48
`define SPC_D_LIMX_HI 51
`define SPC_D_G 55
`define SPC_D_BASEX_LO 56
`define SPC_D_UP_LO 48
`define SPC_D_WC_LO 32
`define SPC_D_WC_HI 36
`define SPC_SEL_TI 2
`define SPC_SEL_IDX_LO 3
`define SPC_PAGE_FILL 12'hfff
`define SPC_VEC_NP 8'h0b
`define SPC_VEC_SS 8'h0c
`define SPC_VEC_GP 8'h0d
`define SPC_REG_CTRL 8'h00
`define SPC_REG_STATUS 8'h04
`define SPC_REG_FCNT 8'h08
`define SPC_CTRL_RST 1'b1
`define SPC_RESP_OKAY 2'h0
`define SPC_RESP_SLVERR 2'h2
`endif

/* pkg/spc_pkg.sv */
// Types for the segment protection checker.
// Assumes spc_cfg.svh is on the include path.
`include "spc_cfg.svh"
package spc_pkg;
  typedef enum logic [1:0] {IDLE, FETCH, CHECK} spc_phase_t;
  typedef struct packed {
    logic valid;
    logic [2:0] seg;
    logic [15:0] sel;
    logic viaGate;
  } spc_load_t;
  typedef struct packed {
    logic valid;
    logic table_indicator;
    logic [12:0] index;
  } spc_ref_t;
  typedef struct packed {
    logic valid;
    logic [63:0] data;
  } spc_desc_t;
  typedef struct packed {
    logic done;
    logic fault;
    logic [7:0] vector;
  } spc_lrsp_t;
  typedef struct packed {
    logic valid;
    logic [2:0] seg;
    logic [31:0] offset;
    logic write;
    logic exec;
  } spc_acc_t;
  typedef struct packed {
    logic done;
    logic fault;
    logic [7:0] vector;
    logic [31:0] linear;
  } spc_arsp_t;
  typedef struct packed {
    logic valid;
    logic [4:0] count;
    logic wide;
  } spc_param_t;
  typedef struct packed {
    logic valid;
    logic [15:0] sel;
    logic [31:0] base;
    logic [31:0] limit;
    logic [7:0] access;
  } spc_cache_t;
  typedef struct packed {
    spc_phase_t phase;
    spc_load_t req;
    logic [63:0] desc;
    spc_cache_t [`SPC_NSEG-1:0] cache;
    logic [1:0] current_level;
    spc_lrsp_t lrsp;
    spc_ref_t mark;
    spc_arsp_t arsp;
    spc_param_t param;
    logic checkEn;
    logic [7:0] lastVec;
    logic [31:0] faultCnt;
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } spc_st_t;
endpackage

/* hdl/spc_segment_check.sv */
// Segment descriptor decode, per-segment descriptor cache and
// privilege checks, with an AXI4-Lite control/status slave.
// Assumes the core runs on sys_clk and answers fetch requests.
// What this block does
// - Not-present descriptor faults access, no base/limit
// - Descriptor level is two-bit level 0..3
// - Access byte: present 7, level 6:5, class 4
// - Class 1 code/data, class 0 system/gate
// - Data bit 2 picks expand up/down limit test
// - Data writes refused when writeable bit clear
// - Conforming code: current >= descriptor, level kept
// - Code data-reads refused when readable bit clear
// - Accessed bit set on load or selector test
// - Granularity picks byte or page limit
// - Native and legacy system descriptor formats
// - Gate word count, 16- or 32-bit items
// - Selector split: table, index, requestor level
// - Segment load fetches 8-byte descriptor into cache
// - Cache changes only on segment reload
// - Four levels, zero most privileged
// - Data access needs current <= effective level
// - Call needs current >= code segment level
// - Current level changes only via gate transfer
// - Requestor level is selector bits 1:0
// - Index is selector upper 13 bits
// - Effective level is max of requestor, descriptor
// - Current level copied to code selector low bits, not for conforming
`timescale 1ns/1ps
`default_nettype none
`include "spc_cfg.svh"
module spc_segment_check (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire spc_pkg::spc_load_t loadReq,
  output logic loadReady,
  output spc_pkg::spc_ref_t fetchReq,
  input wire spc_pkg::spc_desc_t fetchRsp,
  output spc_pkg::spc_lrsp_t loadRsp,
  output spc_pkg::spc_ref_t markOut,
  input wire spc_pkg::spc_acc_t accReq,
  output spc_pkg::spc_arsp_t accRsp,
  input wire spc_pkg::spc_desc_t gateIn,
  output spc_pkg::spc_param_t paramOut,
  output logic [1:0] currentLevel
);
  spc_pkg::spc_st_t st;
  spc_pkg::spc_st_t next_st;

  // Descriptor decode of the latched fetch
  logic [7:0] dAcc;
  logic dP, dS, dE, dBit2, dBit1, dLegacy;
  logic [1:0] dLevel, reqLevel, effLevel, cur;
  logic [19:0] dRawLim;
  logic [31:0] dBase, dLimit;
  logic loadOk, csLoad, inPlace;
  logic [7:0] loadVec;
  logic [1:0] newLevel;
  always_comb begin
    dAcc = st.desc[`SPC_D_ACC_HI:`SPC_D_ACC_LO];
    dP = dAcc[`SPC_AB_P];
    dLevel = dAcc[`SPC_AB_DPL_HI:`SPC_AB_DPL_LO];
    dS = dAcc[`SPC_AB_S];
    dE = dAcc[`SPC_AB_E];
    dBit2 = dAcc[`SPC_AB_ED];
    dBit1 = dAcc[`SPC_AB_W];
    // Legacy system format has zero upper word
    dLegacy = !dS && (st.desc[63:`SPC_D_UP_LO] == 16'h0000);
    dBase[23:0] = st.desc[`SPC_D_BASE_HI:`SPC_D_BASE_LO];
    dBase[31:24] = dLegacy ? 8'h00 : st.desc[63:`SPC_D_BASEX_LO];
    dRawLim[15:0] = st.desc[`SPC_D_LIM_HI:0];
    dRawLim[19:16] = dLegacy ? 4'h0 : st.desc[`SPC_D_LIMX_HI:`SPC_D_LIMX_LO];
    // Page granular limit fills the low page offset
    if (st.desc[`SPC_D_G] && !dLegacy)
      dLimit = {dRawLim, `SPC_PAGE_FILL};
    else
      dLimit = {12'h000, dRawLim};
    reqLevel = st.req.sel[1:0];
    effLevel = (reqLevel > dLevel) ? reqLevel : dLevel;
    cur = st.current_level;
    csLoad = (st.req.seg == `SPC_SEG_CS);
    newLevel = cur;
    loadOk = 1'b0;
    loadVec = `SPC_VEC_GP;
    if (!dP) begin
      // Not present: nothing else of the descriptor is trusted
      loadVec = (st.req.seg == `SPC_SEG_SS) ? `SPC_VEC_SS : `SPC_VEC_NP;
    end else if (st.req.seg == `SPC_SEG_TEST) begin
      loadOk = 1'b1;
    end else if (csLoad) begin
      if (dS && dE) begin
        if (dBit2) begin
          loadOk = (cur >= dLevel);
        end else if (st.req.viaGate) begin
          loadOk = (cur >= dLevel);
          // Level only moves inward: no return path is modelled
          newLevel = dLevel;
        end else begin
          loadOk = (dLevel == cur);
        end
      end
    end else if (st.req.seg == `SPC_SEG_SS) begin
      loadOk = dS && !dE && dBit1 && (dLevel == cur) && (reqLevel == cur);
    end else begin
      // Data or readable code; conforming code skips the level test
      loadOk = dS && (!dE || dBit1) && ((dE && dBit2) || (effLevel >= cur));
    end
    inPlace = (st.req.seg != `SPC_SEG_TEST);
  end

  // Access check against the cached descriptor
  spc_pkg::spc_cache_t ent;
  logic accNp, accTypeBad, accLimBad;
  always_comb begin
    ent = st.cache[accReq.seg];
    accNp = !ent.valid || !ent.access[`SPC_AB_P];
    accTypeBad = 1'b0;
    if (ent.access[`SPC_AB_E]) begin
      // Code: no writes, data reads only if readable
      accTypeBad = accReq.write || (!accReq.exec && !ent.access[`SPC_AB_W]);
    end else begin
      // Data: writes need writeable, never executed
      accTypeBad = accReq.exec || (accReq.write && !ent.access[`SPC_AB_W]);
    end
    if (!ent.access[`SPC_AB_E] && ent.access[`SPC_AB_ED])
      accLimBad = (accReq.offset <= ent.limit);
    else
      accLimBad = (accReq.offset > ent.limit);
  end

  logic wrFire, rdFire, wrMapped, faultEvt, fcntClr;
  always_comb begin
    next_st = st;
    loadReady = (st.phase == spc_pkg::IDLE);
    next_st.lrsp.done = 1'b0;
    next_st.mark.valid = 1'b0;
    next_st.arsp.done = 1'b0;
    next_st.param.valid = 1'b0;
    faultEvt = 1'b0;
    unique case (st.phase)
      spc_pkg::IDLE: begin
        if (loadReq.valid) begin
          next_st.req = loadReq;
          next_st.phase = spc_pkg::FETCH;
        end
      end
      spc_pkg::FETCH: begin
        if (fetchRsp.valid) begin
          next_st.desc = fetchRsp.data;
          next_st.phase = spc_pkg::CHECK;
        end
      end
      spc_pkg::CHECK: begin
        next_st.phase = spc_pkg::IDLE;
        next_st.lrsp.done = 1'b1;
        next_st.lrsp.fault = !loadOk;
        next_st.lrsp.vector = loadOk ? 8'h00 : loadVec;
        faultEvt = !loadOk;
        if (loadOk) begin
          // Write-back of the accessed bit to the table
          next_st.mark.valid = 1'b1;
          next_st.mark.table_indicator = st.req.sel[`SPC_SEL_TI];
          next_st.mark.index = st.req.sel[15:`SPC_SEL_IDX_LO];
          if (inPlace) begin
            // Only a reload refreshes an entry
            next_st.cache[st.req.seg].valid = 1'b1;
            next_st.cache[st.req.seg].sel = st.req.sel;
            next_st.cache[st.req.seg].base = dBase;
            next_st.cache[st.req.seg].limit = dLimit;
            next_st.cache[st.req.seg].access = dAcc | 8'h01;
          end
          if (csLoad && !(dE && dBit2)) begin
            // Code selector low bits carry the current level
            next_st.current_level = newLevel;
            next_st.cache[`SPC_SEG_CS].sel[1:0] = newLevel;
          end
        end
      end
      default: next_st.phase = spc_pkg::IDLE;
    endcase

    if (accReq.valid) begin
      next_st.arsp.done = 1'b1;
      next_st.arsp.fault = 1'b0;
      next_st.arsp.vector = 8'h00;
      next_st.arsp.linear = 32'h0000_0000;
      if (accNp) begin
        next_st.arsp.fault = 1'b1;
        next_st.arsp.vector = (accReq.seg == `SPC_SEG_SS) ? `SPC_VEC_SS : `SPC_VEC_NP;
      end else if (st.checkEn && (accTypeBad || accLimBad)) begin
        next_st.arsp.fault = 1'b1;
        next_st.arsp.vector = `SPC_VEC_GP;
      end else begin
        next_st.arsp.linear = ent.base + accReq.offset;
      end
      faultEvt = faultEvt || next_st.arsp.fault;
    end

    if (gateIn.valid) begin
      next_st.param.valid = 1'b1;
      next_st.param.count = gateIn.data[`SPC_D_WC_HI:`SPC_D_WC_LO];
      next_st.param.wide = (gateIn.data[63:`SPC_D_UP_LO] != 16'h0000);
    end

    // AXI4-Lite slave: address and data may come in either order
    s_axi_awready = !st.awHeld && !st.bvalid;
    s_axi_wready = !st.wHeld && !st.bvalid;
    s_axi_arready = !st.rvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.wHeld = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    wrFire = st.awHeld && st.wHeld && !st.bvalid;
    wrMapped = (st.awAddr == `SPC_REG_CTRL) || (st.awAddr == `SPC_REG_STATUS) ||
               (st.awAddr == `SPC_REG_FCNT);
    fcntClr = wrFire && (st.awAddr == `SPC_REG_FCNT) && st.wStrb[0];
    if (wrFire) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = wrMapped ? `SPC_RESP_OKAY : `SPC_RESP_SLVERR;
      if (st.awAddr == `SPC_REG_CTRL && st.wStrb[0])
        next_st.checkEn = st.wData[0];
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    // A fault in the clearing cycle still counts
    if (faultEvt) begin
      next_st.faultCnt = fcntClr ? 32'h0000_0001 : st.faultCnt + 32'h0000_0001;
      // Access flags hold stale values when no access ran this cycle
      next_st.lastVec = (accReq.valid && next_st.arsp.fault) ? next_st.arsp.vector :
                        next_st.lrsp.vector;
    end else if (fcntClr) begin
      next_st.faultCnt = 32'h0000_0000;
    end
    rdFire = s_axi_arvalid && s_axi_arready;
    if (rdFire) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `SPC_RESP_OKAY;
      unique case (s_axi_araddr)
        `SPC_REG_CTRL: next_st.rdata = {31'h0, st.checkEn};
        `SPC_REG_STATUS: next_st.rdata = {15'h0, loadReady == 1'b0, st.lastVec, 6'h0,
                                          st.current_level};
        `SPC_REG_FCNT: next_st.rdata = st.faultCnt;
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = `SPC_RESP_SLVERR;
        end
      endcase
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.checkEn <= `SPC_CTRL_RST;
    end else begin
      st <= next_st;
    end
  end

  // Fetch reference from the latched selector
  assign fetchReq.valid = (st.phase == spc_pkg::FETCH);
  assign fetchReq.table_indicator = st.req.sel[`SPC_SEL_TI];
  assign fetchReq.index = st.req.sel[15:`SPC_SEL_IDX_LO];
  assign loadRsp = st.lrsp;
  assign markOut = st.mark;
  assign accRsp = st.arsp;
  assign paramOut = st.param;
  assign currentLevel = st.current_level;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;

  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_np_fault: assert property (accReq.valid && accNp |=>
    accRsp.fault && accRsp.linear == 32'h0 && accRsp.vector != `SPC_VEC_GP)
    else $error("not-present access not faulted");
  a_ro_write: assert property (accReq.valid && !accNp && st.checkEn && accReq.write &&
    !ent.access[`SPC_AB_E] && !ent.access[`SPC_AB_W] |=> accRsp.fault)
    else $error("write to read-only data allowed");
  a_code_read: assert property (accReq.valid && !accNp && st.checkEn && !accReq.write &&
    !accReq.exec && ent.access[`SPC_AB_E] && !ent.access[`SPC_AB_W] |=> accRsp.fault)
    else $error("read of execute-only code allowed");
  a_expand_down: assert property (accReq.valid && !accNp && st.checkEn &&
    !ent.access[`SPC_AB_E] && ent.access[`SPC_AB_ED] && accReq.offset <= ent.limit
    |=> accRsp.vector == `SPC_VEC_GP)
    else $error("expand-down offset at or below limit allowed");
  a_fetch_sel: assert property (loadReq.valid && loadReady |=>
    fetchReq.valid && fetchReq.index == $past(loadReq.sel[15:3]) &&
    fetchReq.table_indicator == $past(loadReq.sel[2]))
    else $error("fetch reference does not match selector");
  a_mark_set: assert property (loadRsp.done && !loadRsp.fault |-> markOut.valid)
    else $error("accessed bit not written back");
  a_cache_hold: assert property (st.phase != spc_pkg::CHECK |=> $stable(st.cache))
    else $error("cache changed without a reload");
  a_level_gate: assert property ($changed(st.current_level) |->
    $past(st.phase) == spc_pkg::CHECK && $past(st.req.viaGate) && $past(csLoad))
    else $error("current level changed outside gate transfer");
  a_eff_level: assert property (effLevel >= reqLevel && effLevel >= dLevel &&
    (effLevel == reqLevel || effLevel == dLevel))
    else $error("effective level is not the maximum");
  a_param_wide: assert property (gateIn.valid |=> paramOut.valid &&
    paramOut.wide == ($past(gateIn.data[63:48]) != 16'h0))
    else $error("gate item width wrong");

  a_conform_keep: assert property (st.phase == spc_pkg::CHECK && csLoad && dP &&
    dS && dE && dBit2 |=> loadRsp.fault == $past(cur < dLevel) &&
    currentLevel == $past(cur))
    else $error("conforming code level test wrong");
  a_call_level: assert property (st.phase == spc_pkg::CHECK && csLoad && dP && dS &&
    dE && cur < dLevel |=> loadRsp.fault)
    else $error("call to outer level allowed");
  a_class_sys: assert property (st.phase == spc_pkg::CHECK && dP && !dS &&
    st.req.seg != `SPC_SEG_TEST |=> loadRsp.fault)
    else $error("system descriptor loaded into segment");
  a_gran_limit: assert property (st.phase == spc_pkg::CHECK && loadOk && inPlace &&
    dS && st.desc[`SPC_D_G] |=> st.cache[st.req.seg].limit ==
    {$past(st.desc[`SPC_D_LIMX_HI:`SPC_D_LIMX_LO]), $past(st.desc[`SPC_D_LIM_HI:0]), 12'hfff})
    else $error("page granular limit not scaled");
  a_acc_mark: assert property (st.phase == spc_pkg::CHECK && loadOk && inPlace |=>
    st.cache[st.req.seg].access[`SPC_AB_A])
    else $error("accessed bit not set in cache");
  a_cs_low: assert property (!(st.cache[`SPC_SEG_CS].access[`SPC_AB_E] &&
    st.cache[`SPC_SEG_CS].access[`SPC_AB_ED]) |->
    currentLevel == st.cache[`SPC_SEG_CS].sel[1:0])
    else $error("current level differs from code selector");
  a_np_load: assert property (st.phase == spc_pkg::CHECK && !dP |=> loadRsp.fault &&
    !markOut.valid && loadRsp.vector != `SPC_VEC_GP)
    else $error("not-present load accepted");
  a_data_level: assert property (st.phase == spc_pkg::CHECK && dP && dS && !dE &&
    !csLoad && st.req.seg != `SPC_SEG_SS && st.req.seg != `SPC_SEG_TEST |=>
    loadRsp.fault == $past(effLevel < cur))
    else $error("data level test wrong");
  a_desc_latch: assert property (st.phase == spc_pkg::FETCH && fetchRsp.valid |=>
    st.phase == spc_pkg::CHECK && st.desc == $past(fetchRsp.data))
    else $error("fetched descriptor not latched");

  // One load touches only its own entry
  for (genvar g = 0; g < `SPC_NSEG; g++) begin : g_keep
    a_entry_keep: assert property (st.req.seg != g |=> $stable(st.cache[g]))
      else $error("other cache entry changed");
  end

  c_load_ok: cover property (loadRsp.done && !loadRsp.fault);
  c_gate_level: cover property ($changed(st.current_level));
  c_acc_np: cover property (accRsp.done && accRsp.vector == `SPC_VEC_NP);
  c_acc_ok: cover property (accRsp.done && !accRsp.fault);
  c_acc_gp: cover property (accRsp.done && accRsp.vector == `SPC_VEC_GP);
endmodule
`default_nettype wire

/* testbench/spc_core_model.sv */
// Core-side model: answers descriptor fetches from a small table.
// Assumes the bench fills tbl and sets lag, the answer delay.
`timescale 1ns/1ps
`default_nettype none
module spc_core_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] lag,
  input wire spc_pkg::spc_ref_t fetchReq,
  output spc_pkg::spc_desc_t fetchRsp
);
  logic [63:0] tbl [0:15];
  logic [1:0] cnt;
  // Idle data flips so a stale word never passes for an answer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetchRsp <= '0;
      cnt <= 2'h0;
    end else if (fetchRsp.valid) begin
      fetchRsp.valid <= 1'b0;
      fetchRsp.data <= ~fetchRsp.data;
      cnt <= 2'h0;
    end else if (fetchReq.valid && cnt == lag) begin
      fetchRsp.valid <= 1'b1;
      fetchRsp.data <= tbl[{fetchReq.table_indicator, fetchReq.index[2:0]}];
    end else begin
      fetchRsp.data <= ~fetchRsp.data;
      if (fetchReq.valid) begin
        cnt <= cnt + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Bench for the segment checker: register, load, access and gate tests.
// Assumes spc_pkg and the core model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "spc_cfg.svh"
module tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, loadReady;
  logic [1:0] bresp, rresp, currentLevel;
  logic [1:0] lag = 2'h0;
  logic [31:0] rdata;
  spc_pkg::spc_load_t loadReq = '0;
  spc_pkg::spc_acc_t accReq = '0;
  spc_pkg::spc_desc_t gateIn = '0;
  spc_pkg::spc_desc_t fetchRsp;
  spc_pkg::spc_ref_t fetchReq, markOut;
  spc_pkg::spc_lrsp_t loadRsp;
  spc_pkg::spc_arsp_t accRsp;
  spc_pkg::spc_param_t paramOut;
  int failCount = 0;
  int numChecks = 0;

  always #4 sys_clk = ~sys_clk;

  spc_segment_check dut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .loadReq(loadReq),
    .loadReady(loadReady), .fetchReq(fetchReq), .fetchRsp(fetchRsp), .loadRsp(loadRsp),
    .markOut(markOut), .accReq(accReq), .accRsp(accRsp), .gateIn(gateIn),
    .paramOut(paramOut), .currentLevel(currentLevel));
  spc_core_model core (.sys_clk(sys_clk), .rst_n(rst_n), .lag(lag), .fetchReq(fetchReq),
    .fetchRsp(fetchRsp));

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic printVerdict();
    if (failCount == 0 && numChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [63:0] dsc(input logic [31:0] b, input logic [19:0] l,
    input logic [7:0] a, input logic g);
    return {b[31:24], g, 3'h0, l[19:16], a, b[23:0], l[15:0]};
  endfunction

  function automatic logic [15:0] sl(input logic [12:0] i, input logic t, input logic [1:0] r);
    return {i, t, r};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    #1;
    while (awvalid || wvalid) begin
      @(negedge sys_clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      @(posedge sys_clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      #1;
    end
    while (bvalid !== 1'b1) @(negedge sys_clk);
    chk("bresp", bresp, er);
    @(posedge sys_clk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic h;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    #1;
    while (arvalid) begin
      @(negedge sys_clk);
      h = arready;
      @(posedge sys_clk);
      if (h) arvalid <= 1'b0;
      #1;
    end
    while (rvalid !== 1'b1) @(negedge sys_clk);
    chk("rdata", rdata, exp);
    chk("rresp", rresp, er);
    @(posedge sys_clk);
    rready <= 1'b0;
  endtask

  task automatic ld(input logic [2:0] sg, input logic [15:0] s, input logic g,
    input logic [7:0] v);
    @(posedge sys_clk);
    loadReq <= '{1'b1, sg, s, g};
    @(posedge sys_clk);
    loadReq <= '0;
    #1;
    while (loadRsp.done !== 1'b1) begin
      @(posedge sys_clk);
      #1;
    end
    chk("load vector", loadRsp.vector, v);
    chk("load fault", loadRsp.fault, v != 8'h00);
    chk("mark valid", markOut.valid, v == 8'h00);
    if (v == 8'h00) chk("mark", {markOut.table_indicator, markOut.index}, {s[2], s[15:3]});
  endtask

  // Expected linear of zero stands for a refused access
  task automatic ac(input logic [2:0] sg, input logic [31:0] o, input logic w, input logic x,
    input logic [31:0] lin);
    @(posedge sys_clk);
    accReq <= '{1'b1, sg, o, w, x};
    @(posedge sys_clk);
    accReq <= '0;
    #1;
    chk("acc done", accRsp.done, 1'b1);
    chk("acc vector", accRsp.vector, lin == 32'h0 ? `SPC_VEC_GP : 8'h00);
    chk("acc linear", accRsp.linear, lin);
  endtask

  task automatic gt(input logic [63:0] d, input logic [4:0] n, input logic wd);
    @(posedge sys_clk);
    gateIn <= '{1'b1, d};
    @(posedge sys_clk);
    gateIn <= '0;
    #1;
    chk("param", paramOut, {1'b1, n, wd});
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    failCount++;
    printVerdict();
  end

  initial begin
    core.tbl[0] = dsc(32'h12345000, 20'h00fff, 8'h92, 1'b0);
    core.tbl[1] = dsc(32'h20000000, 20'h00100, 8'h90, 1'b0);
    core.tbl[2] = dsc(32'h30000000, 20'h00fff, 8'h96, 1'b0);
    core.tbl[3] = dsc(32'h40000000, 20'h00000, 8'h92, 1'b1);
    core.tbl[4] = dsc(32'h41000000, 20'hfffff, 8'h12, 1'b0);
    core.tbl[5] = dsc(32'h50000000, 20'h00fff, 8'h9c, 1'b0);
    core.tbl[6] = dsc(32'h51000000, 20'h00fff, 8'hbe, 1'b0);
    core.tbl[7] = dsc(32'h52000000, 20'h00fff, 8'hba, 1'b0);
    core.tbl[8] = dsc(32'h53000000, 20'h00fff, 8'h82, 1'b0);
    core.tbl[9] = dsc(32'h54000000, 20'h000ff, 8'h92, 1'b0);
    core.tbl[10] = dsc(32'h55000000, 20'h00fff, 8'h9a, 1'b0);
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk("level", currentLevel, 2'h0);
    rd(`SPC_REG_CTRL, 32'h1, `SPC_RESP_OKAY);
    rd(8'h0c, 32'h0, `SPC_RESP_SLVERR);
    wr(8'h10, 32'h0, `SPC_RESP_SLVERR);
    ld(3, sl(4, 0, 0), 0, `SPC_VEC_NP);
    ld(2, sl(4, 0, 0), 0, `SPC_VEC_SS);
    ld(3, sl(0, 0, 0), 0, 8'h00);
    ac(3, 32'h10, 1, 0, 32'h12345010);
    ac(3, 32'hfff, 0, 0, 32'h12345fff);
    ac(3, 32'h1000, 0, 0, 32'h0);
    lag <= 2'h2;
    ld(4, sl(1, 0, 3), 0, 8'h00);
    ac(4, 32'h4, 1, 0, 32'h0);
    ac(4, 32'h4, 0, 0, 32'h20000004);
    ld(5, sl(2, 0, 0), 0, 8'h00);
    ac(5, 32'hfff, 0, 0, 32'h0);
    ac(5, 32'h1000, 0, 0, 32'h30001000);
    ld(0, sl(3, 0, 0), 0, 8'h00);
    ac(0, 32'hfff, 0, 0, 32'h40000fff);
    ac(0, 32'h1000, 0, 0, 32'h0);
    lag <= 2'h0;
    ld(3, sl(1, 1, 0), 0, 8'h00);
    ac(3, 32'h20, 0, 0, 32'h54000020);
    ld(7, sl(1, 1, 2), 0, 8'h00);
    ld(3, sl(0, 1, 0), 0, `SPC_VEC_GP);
    ld(3, sl(0, 0, 0), 0, 8'h00);
    core.tbl[0] = dsc(32'h60000000, 20'h00fff, 8'h92, 1'b0);
    ac(3, 32'h10, 0, 0, 32'h12345010);
    ld(3, sl(0, 0, 0), 0, 8'h00);
    ac(3, 32'h10, 0, 0, 32'h60000010);
    ld(2, sl(0, 0, 1), 0, `SPC_VEC_GP);
    ld(2, sl(1, 0, 0), 0, `SPC_VEC_GP);
    ld(2, sl(0, 0, 0), 0, 8'h00);
    ld(1, sl(6, 0, 0), 0, `SPC_VEC_GP);
    ld(1, sl(7, 0, 0), 0, `SPC_VEC_GP);
    ld(1, sl(7, 0, 0), 1, `SPC_VEC_GP);
    ld(1, sl(5, 0, 0), 0, 8'h00);
    chk("level", currentLevel, 2'h0);
    ac(1, 32'h8, 0, 0, 32'h0);
    ac(1, 32'h8, 0, 1, 32'h50000008);
    ld(4, sl(5, 0, 0), 0, `SPC_VEC_GP);
    ld(4, sl(6, 0, 0), 0, 8'h00);
    ld(1, sl(2, 1, 2), 0, 8'h00);
    chk("level", currentLevel, 2'h0);
    gt({16'h0008, 8'h8c, 3'h0, 5'h05, 32'h0}, 5'h05, 1'b1);
    gt({16'h0000, 8'h84, 3'h0, 5'h1f, 32'h0}, 5'h1f, 1'b0);
    wr(`SPC_REG_CTRL, 32'h0, `SPC_RESP_OKAY);
    ac(3, 32'h2000, 0, 0, 32'h60002000);
    ld(3, sl(4, 0, 0), 0, `SPC_VEC_NP);
    wr(`SPC_REG_CTRL, 32'h1, `SPC_RESP_OKAY);
    wr(`SPC_REG_FCNT, 32'h0, `SPC_RESP_OKAY);
    ac(3, 32'h2000, 0, 0, 32'h0);
    rd(`SPC_REG_FCNT, 32'h1, `SPC_RESP_OKAY);
    rd(`SPC_REG_STATUS, {16'h0, `SPC_VEC_GP, 8'h00}, `SPC_RESP_OKAY);
    ld(3, sl(4, 0, 0), 0, `SPC_VEC_NP);
    rd(`SPC_REG_STATUS, {16'h0, `SPC_VEC_NP, 8'h00}, `SPC_RESP_OKAY);
    printVerdict();
  end
endmodule
`default_nettype wire
